// ### design/cssp_pkg.sv
// shared constants, types and helpers of the codec control serial port
package cssp_pkg;

    // field widths of the command and data bytes
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int PAGE_COUNT = 2;
    localparam int REG_COUNT = 128;
    localparam int PAGE_BIT = 0;

    // bit counter and address limits
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [6:0] PAGE_CTRL_ADDR = 7'h00;
    localparam logic [6:0] LAST_ADDR = 7'h7F;

    // reset values
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] IDLE_BYTE = 8'h00;

    // fixed upper part of the two-wire slave address
    localparam logic [4:0] TWO_WIRE_BASE = 5'h06;

    // strap capture: latch once the two-flop synchroniser has settled
    localparam logic [1:0] STRAP_LATCH = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;

    // timing: least hardware reset pulse, kept for the bench
    localparam int CLK_PERIOD_NS = 25;
    localparam int HW_RST_MIN_NS = 10;
    localparam int HW_RST_MIN_CYC_RAW = (HW_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HW_RST_MIN_CYC = (HW_RST_MIN_CYC_RAW < 1) ? 1 : HW_RST_MIN_CYC_RAW;

    // frame phase of the serial slave
    typedef enum logic [2:0] {
        PH_CMD = 3'b001,
        PH_DATA = 3'b010,
        PH_HALT = 3'b100
    } cssp_phase_t;

    // receive side state, clocked on the falling serial clock edge
    typedef struct packed {
        logic [6:0] rxShift;
        logic [2:0] bitCnt;
        cssp_phase_t phase;
        logic readDir;
        logic [6:0] regAddr;
    } cssp_rx_t;

    // transmit side state, clocked on the rising serial clock edge
    typedef struct packed {
        logic [7:0] txShift;
    } cssp_tx_t;

    // register bank state in the link domain
    typedef struct packed {
        logic modeS1;
        logic modeS2;
        logic [7:0] pageReg;
        logic evtToggle;
        logic heldPage;
        logic [6:0] heldAddr;
        logic [7:0] heldData;
    } cssp_bank_t;

    // system clock side state
    typedef struct packed {
        logic strapS1;
        logic strapS2;
        logic [1:0] strapCnt;
        logic spiMode;
        logic pin0S1;
        logic pin0S2;
        logic pin1S1;
        logic pin1S2;
        logic [6:0] twoWireAddr;
        logic evtS1;
        logic evtS2;
        logic evtS3;
        logic updValid;
        logic updPage;
        logic [6:0] updAddr;
        logic [7:0] updData;
    } cssp_sys_t;

    // address zero of every page is the page control register
    function automatic logic isPageCtrl(input logic [6:0] addr);
        return addr == PAGE_CTRL_ADDR;
    endfunction

endpackage

// ### design/cssp_reg_bank.sv
// paged register storage and write-event holding in the serial clock domain
`timescale 1ns/1ps
`default_nettype none
module cssp_reg_bank
    import cssp_pkg::*;
(
    input wire logic linkClk,
    input wire logic sys_rst,
    input wire logic strapPin,
    input wire logic wrEn,
    input wire logic [6:0] wrAddr,
    input wire logic [7:0] wrData,
    input wire logic [6:0] rdAddr,
    output logic [7:0] rdData,
    output logic spiModeLink,
    output logic evtToggle,
    output logic heldPage,
    output logic [6:0] heldAddr,
    output logic [7:0] heldData
);

    cssp_bank_t st_r;
    cssp_bank_t st_nxt;
    logic [7:0] mem [PAGE_COUNT*REG_COUNT];

    // page select, strap sync and the word handed to the system clock
    always_comb begin
        st_nxt = st_r;
        st_nxt.modeS1 = strapPin;
        st_nxt.modeS2 = st_r.modeS1;
        if (wrEn) begin
            if (isPageCtrl(wrAddr)) begin
                st_nxt.pageReg = wrData;
            end
            // held word stays put until the next write, which is a byte later
            st_nxt.heldPage = st_r.pageReg[PAGE_BIT];
            st_nxt.heldAddr = wrAddr;
            st_nxt.heldData = wrData;
            st_nxt.evtToggle = ~st_r.evtToggle;
        end
    end

    // page survives frames; only hardware reset returns it to page 0
    always_ff @(negedge linkClk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '{modeS1: 1'b0, modeS2: 1'b0, pageReg: PAGE_RST, evtToggle: 1'b0,
                      heldPage: 1'b0, heldAddr: PAGE_CTRL_ADDR, heldData: IDLE_BYTE};
        end else begin
            st_r <= st_nxt;
        end
    end

    // storage has no reset; contents are defined by host writes
    always_ff @(negedge linkClk) begin
        if (wrEn && !isPageCtrl(wrAddr)) begin
            mem[{st_r.pageReg[PAGE_BIT], wrAddr}] <= wrData;
        end
    end

    assign rdData = isPageCtrl(rdAddr) ? st_r.pageReg : mem[{st_r.pageReg[PAGE_BIT], rdAddr}];
    assign spiModeLink = st_r.modeS2;
    assign evtToggle = st_r.evtToggle;
    assign heldPage = st_r.heldPage;
    assign heldAddr = st_r.heldAddr;
    assign heldData = st_r.heldData;

endmodule
`default_nettype wire

// ### design/cssp_control_port.sv
// four-wire serial control slave of the codec with two-wire address strapping
`timescale 1ns/1ps
`default_nettype none
module cssp_control_port
    import cssp_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic protocolStrap,
    input wire logic slaveSelectN,
    input wire logic serialClk,
    input wire logic mosiIn,
    output logic misoOut,
    output logic misoOe,
    output logic spiModeActive,
    output logic [6:0] twoWireAddr,
    output logic regUpdValid,
    output logic regUpdPage,
    output logic [6:0] regUpdAddr,
    output logic [7:0] regUpdData
);

    // link domain: frame state on both serial clock edges
    cssp_rx_t rx_r;
    cssp_rx_t rx_nxt;
    cssp_tx_t tx_r;
    cssp_tx_t tx_nxt;
    // system domain
    cssp_sys_t sys_r;
    cssp_sys_t sys_nxt;

    logic frameRst;
    logic [7:0] byteVal;
    logic wrEn;
    logic [7:0] rdData;
    logic [7:0] readByte;
    logic spiModeLink;
    logic evtToggle;
    logic heldPage;
    logic [6:0] heldAddr;
    logic [7:0] heldData;

    // a deselected port holds its frame logic in reset, so a stray
    // serial clock edge while select is high cannot move the counter;
    // a byte cut short by select rising is dropped with the counter
    // limitation: select must not move within half a bit of a clock edge
    assign frameRst = sys_rst | slaveSelectN;

    // paged storage and the held write word; storage lives in the link
    // domain so a read byte is ready one edge after the command, with no
    // crossing; only the write notice goes over to the system clock
    cssp_reg_bank u_bank (
        .linkClk(serialClk),
        .sys_rst(sys_rst),
        .strapPin(protocolStrap),
        .wrEn(wrEn),
        .wrAddr(rx_r.regAddr),
        .wrData(byteVal),
        .rdAddr(rx_r.regAddr),
        .rdData(rdData),
        .spiModeLink(spiModeLink),
        .evtToggle(evtToggle),
        .heldPage(heldPage),
        .heldAddr(heldAddr),
        .heldData(heldData)
    );

    // receive path: the byte including the bit on the current falling edge
    assign byteVal = {rx_r.rxShift, mosiIn};

    // command decode, write strobe, address walk
    always_comb begin
        rx_nxt = rx_r;
        wrEn = 1'b0;
        rx_nxt.rxShift = byteVal[6:0];
        rx_nxt.bitCnt = rx_r.bitCnt + 3'h1;
        if (rx_r.bitCnt == BIT_LAST) begin
            unique case (rx_r.phase)
                PH_CMD: begin
                    // first full byte of every frame is the command
                    rx_nxt.regAddr = byteVal[7:1];
                    rx_nxt.readDir = byteVal[0];
                    rx_nxt.phase = PH_DATA;
                end
                PH_DATA: begin
                    // write only when the command asked for one; address 127
                    // is still written, then the rest of the frame is dropped
                    wrEn = ~rx_r.readDir & spiModeLink;
                    if (rx_r.regAddr == LAST_ADDR) begin
                        rx_nxt.phase = PH_HALT;
                    end else begin
                        rx_nxt.regAddr = rx_r.regAddr + 7'h01;
                    end
                end
                PH_HALT: begin
                    // past the page end every byte is dropped
                    rx_nxt.phase = PH_HALT;
                end
            endcase
        end
    end

    // mosi is sampled on the falling edge, the second edge of a bit
    // select high resets the frame at once, without a clock edge
    always_ff @(negedge serialClk or posedge frameRst) begin
        if (frameRst) begin
            rx_r <= '{rxShift: 7'h00, bitCnt: BIT_FIRST, phase: PH_CMD, readDir: 1'b0,
                      regAddr: PAGE_CTRL_ADDR};
        end else begin
            rx_r <= rx_nxt;
        end
    end

    // transmit path: register data only in a read's data bytes;
    // command, write and halted bytes send zeros, which the host ignores
    assign readByte = (rx_r.phase == PH_DATA && rx_r.readDir) ? rdData : IDLE_BYTE;

    // load at the first rising edge of each byte, then shift msb first
    always_comb begin
        tx_nxt = tx_r;
        if (rx_r.bitCnt == BIT_FIRST) begin
            tx_nxt.txShift = readByte;
        end else begin
            tx_nxt.txShift = {tx_r.txShift[6:0], 1'b0};
        end
    end

    // miso moves on the rising edge, the first edge of each bit
    always_ff @(posedge serialClk or posedge frameRst) begin
        if (frameRst) begin
            tx_r <= '{txShift: IDLE_BYTE};
        end else begin
            tx_r <= tx_nxt;
        end
    end

    // data out driven only while selected in four-wire mode
    assign misoOut = tx_r.txShift[7];
    assign misoOe = ~slaveSelectN & spiModeLink;

    // system side: strap capture, two-wire address, write event crossing
    always_comb begin
        sys_nxt = sys_r;
        sys_nxt.strapS1 = protocolStrap;
        sys_nxt.strapS2 = sys_r.strapS1;
        sys_nxt.pin0S1 = slaveSelectN;
        sys_nxt.pin0S2 = sys_r.pin0S1;
        sys_nxt.pin1S1 = serialClk;
        sys_nxt.pin1S2 = sys_r.pin1S1;
        sys_nxt.evtS1 = evtToggle;
        sys_nxt.evtS2 = sys_r.evtS1;
        sys_nxt.evtS3 = sys_r.evtS2;
        // the strap is caught once after reset for spiModeActive; later changes are ignored there,
        // but the register bank's copy that gates writes and data out follows the strap pin on falling serial clock edges;
        // a new strap level reaches spiModeActive only after a new reset
        if (sys_r.strapCnt != STRAP_DONE) begin
            sys_nxt.strapCnt = sys_r.strapCnt + 2'h1;
        end
        if (sys_r.strapCnt == STRAP_LATCH) begin
            sys_nxt.spiMode = sys_r.strapS2;
        end
        // pins 0 and 1 are address straps when the two-wire port is chosen;
        // the pins are resampled on every system clock edge, so the address follows them
        if (sys_r.strapCnt == STRAP_DONE && !sys_r.spiMode) begin
            sys_nxt.twoWireAddr = {TWO_WIRE_BASE, sys_r.pin1S2, sys_r.pin0S2};
        end
        // held word has been stable for two system clock edges at least;
        // writes are a byte apart, far more than the three-flop delay here
        sys_nxt.updValid = sys_r.evtS2 ^ sys_r.evtS3;
        if (sys_r.evtS2 ^ sys_r.evtS3) begin
            sys_nxt.updPage = heldPage;
            sys_nxt.updAddr = heldAddr;
            sys_nxt.updData = heldData;
        end
    end

    // hardware reset returns every register here to a constant
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sys_r <= '{strapS1: 1'b0, strapS2: 1'b0, strapCnt: 2'h0, spiMode: 1'b0,
                       pin0S1: 1'b0, pin0S2: 1'b0, pin1S1: 1'b0, pin1S2: 1'b0,
                       twoWireAddr: 7'h00, evtS1: 1'b0, evtS2: 1'b0, evtS3: 1'b0,
                       updValid: 1'b0, updPage: 1'b0, updAddr: PAGE_CTRL_ADDR,
                       updData: IDLE_BYTE};
        end else begin
            sys_r <= sys_nxt;
        end
    end

    // every system side output comes straight from a flop
    assign spiModeActive = sys_r.spiMode;
    assign twoWireAddr = sys_r.twoWireAddr;
    assign regUpdValid = sys_r.updValid;
    assign regUpdPage = sys_r.updPage;
    assign regUpdAddr = sys_r.updAddr;
    assign regUpdData = sys_r.updData;

endmodule
`default_nettype wire

// ### tb/cssp_control_port_props.sv
// assertion checker for the control serial port
`timescale 1ns/1ps
`default_nettype none
module cssp_control_port_props
    import cssp_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic protocolStrap,
    input wire logic slaveSelectN,
    input wire logic serialClk,
    input wire logic mosiIn,
    input wire logic misoOut,
    input wire logic misoOe,
    input wire logic spiModeActive,
    input wire logic [6:0] twoWireAddr,
    input wire logic regUpdValid,
    input wire logic regUpdPage,
    input wire logic [6:0] regUpdAddr,
    input wire logic [7:0] regUpdData
);
    logic pageSeen_r;
    // page as last written, so each write can be tied to it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pageSeen_r <= 1'b0;
        end else if (regUpdValid && regUpdAddr == PAGE_CTRL_ADDR) begin
            pageSeen_r <= regUpdData[PAGE_BIT];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_rel; slaveSelectN |-> !misoOe && !misoOut; endproperty
    property p_edge; $changed(misoOut) && !slaveSelectN |-> $rose(serialClk); endproperty
    property p_gap; regUpdValid |=> !regUpdValid [*8]; endproperty
    property p_hold; !regUpdValid |-> $stable({regUpdPage, regUpdAddr, regUpdData}); endproperty
    property p_mode; regUpdValid |-> spiModeActive; endproperty
    property p_oe; misoOe |-> spiModeActive && !slaveSelectN; endproperty
    property p_twa;
        twoWireAddr != 7'h00 |-> !spiModeActive && twoWireAddr[6:2] == TWO_WIRE_BASE;
    endproperty
    property p_page; regUpdValid |-> regUpdPage == pageSeen_r; endproperty
    a_rel: assert property (p_rel) else $error("data out not released");
    a_edge: assert property (p_edge) else $error("data out moved off rising edge");
    a_gap: assert property (p_gap) else $error("update pulses too close");
    a_hold: assert property (p_hold) else $error("update fields moved");
    a_mode: assert property (p_mode) else $error("write outside four-wire mode");
    a_oe: assert property (p_oe) else $error("data out driven wrongly");
    a_twa: assert property (p_twa) else $error("two-wire address wrong");
    a_page: assert property (p_page) else $error("write page wrong");
    c_wr: cover property (regUpdValid);
    c_pg: cover property (regUpdValid && regUpdAddr == PAGE_CTRL_ADDR);
    c_rd: cover property (misoOe && misoOut);
endmodule
bind cssp_control_port cssp_control_port_props i_cssp_control_port_props (.clk(clk),
    .sys_rst(sys_rst), .protocolStrap(protocolStrap), .slaveSelectN(slaveSelectN),
    .serialClk(serialClk), .mosiIn(mosiIn), .misoOut(misoOut), .misoOe(misoOe),
    .spiModeActive(spiModeActive), .twoWireAddr(twoWireAddr), .regUpdValid(regUpdValid),
    .regUpdPage(regUpdPage), .regUpdAddr(regUpdAddr), .regUpdData(regUpdData));
`default_nettype wire

// ### tb/cssp_host_model.sv
// host side serial master model
`timescale 1ns/1ps
`default_nettype none
module cssp_host_model (
    output logic slaveSelectN,
    output logic serialClk,
    output logic mosiIn,
    input wire logic misoOut,
    input wire logic misoOe
);
    logic misoLast = 1'b0;
    wire logic misoLine;
    // released line shows the inverse of its last level, never a kept value
    assign misoLine = misoOe ? misoOut : ~misoLast;
    initial begin
        slaveSelectN = 1'b1;
        serialClk = 1'b0;
        mosiIn = 1'b0;
    end
    // odd offset keeps serial edges off the system clock edges
    task automatic sel(input logic act);
        #31 slaveSelectN = ~act;
        #31;
    endtask
    // one byte, msb first, clock stands low afterwards
    task automatic xbyte(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            serialClk = 1'b1;
            #20 mosiIn = tx[i];
            #42.5 serialClk = 1'b0;
            rx[i] = misoLine;
            misoLast = misoLine;
            #62.5;
        end
    endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench of the control serial port
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, sys_rst, protocolStrap;
    wire logic slaveSelectN, serialClk, mosiIn, misoOut, misoOe, spiModeActive;
    wire logic regUpdValid, regUpdPage;
    wire logic [6:0] twoWireAddr, regUpdAddr;
    wire logic [7:0] regUpdData;
    int errors = 0;
    int samples_checked = 0;
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    logic [15:0] updq[$];
    cssp_control_port i_cssp_control_port (.clk(clk), .sys_rst(sys_rst),
        .protocolStrap(protocolStrap), .slaveSelectN(slaveSelectN), .serialClk(serialClk),
        .mosiIn(mosiIn), .misoOut(misoOut), .misoOe(misoOe), .spiModeActive(spiModeActive),
        .twoWireAddr(twoWireAddr), .regUpdValid(regUpdValid), .regUpdPage(regUpdPage),
        .regUpdAddr(regUpdAddr), .regUpdData(regUpdData));
    cssp_host_model i_cssp_host_model (.slaveSelectN(slaveSelectN), .serialClk(serialClk),
        .mosiIn(mosiIn), .misoOut(misoOut), .misoOe(misoOe));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // every write notice as {page, address, data}, taken mid-cycle where it is settled
    always @(negedge clk) begin
        if (regUpdValid === 1'b1) updq.push_back({regUpdPage, regUpdAddr, regUpdData});
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chkUpd(input logic [15:0] exp);
        chk("update", exp, (updq.size() > 0) ? updq.pop_front() : 16'hXXXX);
    endtask
    // select held low across all bytes; last byte may be cut short
    task automatic frame(input int lastBits);
        logic [7:0] r;
        rxq = {};
        i_cssp_host_model.sel(1'b1);
        foreach (txq[k]) begin
            i_cssp_host_model.xbyte(txq[k], (k == txq.size() - 1) ? lastBits : 8, r);
            rxq.push_back(r);
        end
        i_cssp_host_model.sel(1'b0);
        repeat (10) @(negedge clk);
    endtask
    task automatic do_reset(input logic strap);
        @(negedge clk);
        sys_rst = 1'b1;
        protocolStrap = strap;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        repeat (10) @(negedge clk);
    endtask
    task automatic t_burst;
        txq = '{8'hFC, 8'hA5, 8'h3C, 8'h99};
        frame(8);
        chkUpd(16'h7EA5);
        chkUpd(16'h7F3C);
        chk("past end", 16'h0, 16'(updq.size()));
        chk("out on write", 16'h0, {8'h0, rxq[1]});
        // read the last address, then one byte past the page end
        txq = '{8'hFF, 8'h00, 8'h00};
        frame(8);
        chk("read 127", 16'h3C, {8'h0, rxq[1]});
        chk("read past end", 16'h0, {8'h0, rxq[2]});
        chk("burst read wrote", 16'h0, 16'(updq.size()));
    endtask
    task automatic t_page;
        txq = '{8'h00, 8'h01};
        frame(8);
        chkUpd(16'h0001);
        txq = '{8'h0A, 8'h5A, 8'hC3};
        frame(8);
        chkUpd(16'h855A);
        chkUpd(16'h86C3);
        txq = '{8'h0B, 8'hFF, 8'hFF};
        frame(8);
        chk("out on command", 16'h0, {8'h0, rxq[0]});
        chk("read 5", 16'h5A, {8'h0, rxq[1]});
        chk("read 6", 16'hC3, {8'h0, rxq[2]});
        chk("read wrote", 16'h0, 16'(updq.size()));
        txq = '{8'h01, 8'h00};
        frame(8);
        chk("read page", 16'h01, {8'h0, rxq[1]});
        txq = '{8'h00, 8'h00};
        frame(8);
        chkUpd(16'h8000);
    endtask
    task automatic t_abort;
        txq = '{8'h20, 8'h77};
        frame(4);
        chk("partial", 16'h0, 16'(updq.size()));
        chk("idle enable", 16'h0, {15'h0, misoOe});
        frame(8);
        chkUpd(16'h1077);
    endtask
    task automatic t_strap;
        do_reset(1'b0);
        chk("mode", 16'h0, {15'h0, spiModeActive});
        chk("two-wire addr", 16'h19, {9'h0, twoWireAddr});
        txq = '{8'h20, 8'h11};
        frame(8);
        chk("strap low write", 16'h0, 16'(updq.size()));
        do_reset(1'b1);
        chk("mode", 16'h1, {15'h0, spiModeActive});
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        protocolStrap = 1'b1;
        do_reset(1'b1);
        t_burst();
        t_page();
        t_abort();
        t_strap();
        close_out();
    end
    // the sequence needs well under 100 us; a hang is cut at 500 us
    initial begin
        #500000;
        errors++;
        close_out();
    end
endmodule
`default_nettype wire
